// file: core/scc_regs.sv
// Control register bank: soft reset, operating mode, FIFO and slot setup,
// plus the second slot's FIFO word serialiser.
// Assumes a serial port front end delivers decoded accesses on i_clock and
// that averaging factors come from the timing registers on the same clock.
`timescale 1ns/1ps
module scc_regs #(
  parameter int SUM_W = 27
) (
  // Clock and reset
  input  wire logic                     i_clock,
  input  wire logic                     i_sys_rst,
  // Register port
  input  wire scc_pkg::scc_reg_req_s    i_reg,
  output logic                          o_reg_ack,
  output logic [15:0]                   o_reg_rdata,
  // Configuration out
  output scc_pkg::scc_mode_e            o_mode,
  output scc_pkg::scc_cfg_s             o_cfg,
  output logic                          o_soft_reset,
  // Second slot samples
  input  wire logic [2:0]               i_avg_factor_a,
  input  wire logic [2:0]               i_avg_factor_b,
  input  wire scc_pkg::scc_sample_s     i_slotb,
  output logic                          o_slotb_run,
  output logic                          o_slotb_ready,
  // FIFO side
  input  wire logic                     i_fifo_full,
  output logic                          o_fifo_push,
  output logic                          o_fifo_drop_oldest,
  output logic [15:0]                   o_fifo_word,
  output logic                          o_overrun_seen,
  // Extended readback
  input  wire logic [SUM_W-1:0]         i_block_sum,
  output logic      [SUM_W-1:0]         o_readback_value
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic             pending;
    logic             ack;
    logic [15:0]      rdata;
    scc_pkg::scc_mode_e mode;
    scc_pkg::scc_cfg_s  cfg;
    logic             busy;
    logic [3:0]       left;
    logic [2:0]       idx;
    logic [7:0][15:0] words;
  } scc_state_s;

  scc_state_s st;
  scc_state_s next_st;

  function automatic scc_state_s scc_reset_state();
    scc_state_s r;
    r                 = '0;
    r.mode            = scc_pkg::SCC_MODE_STANDBY;
    r.cfg.rdout_fmt   = scc_pkg::SCC_RST_RDOUT_FMT;
    r.cfg.ovrn_policy = scc_pkg::SCC_RST_OVRN_POLICY;
    r.cfg.slotb_fmt   = scc_pkg::SCC_RST_FMT;
    r.cfg.second_slot_enable    = scc_pkg::SCC_RST_SECOND_SLOT_ENABLE;
    r.cfg.slota_fmt   = scc_pkg::SCC_RST_FMT;
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Sample decode
  // ----------------------------------------------------------------
  logic [17:0] sum16_wide;
  logic [15:0] sum16;
  logic [31:0] sum32;
  logic        slotb_avail;
  logic [3:0]  nwords;
  logic        accept;
  logic [15:0] cfg_word;

  // 16-bit sum saturates rather than wrapping, so a bright scene never reads dark
  assign sum16_wide = {2'h0, i_slotb.ch16[0]} + {2'h0, i_slotb.ch16[1]}
                    + {2'h0, i_slotb.ch16[2]} + {2'h0, i_slotb.ch16[3]};
  assign sum16      = (sum16_wide[17:16] != 2'h0) ? 16'hffff : sum16_wide[15:0];
  assign sum32      = i_slotb.ch32[0] + i_slotb.ch32[1] + i_slotb.ch32[2] + i_slotb.ch32[3];

  // Second slot joins the FIFO only with matching averaging or an idle first slot
  assign slotb_avail = (i_avg_factor_a == i_avg_factor_b)
                    || (st.cfg.slota_fmt == scc_pkg::SCC_FMT_NONE);
  assign nwords      = scc_pkg::scc_words(st.cfg.slotb_fmt);
  assign o_slotb_run = st.cfg.second_slot_enable && (st.mode == scc_pkg::SCC_MODE_NORMAL);
  assign o_slotb_ready = !st.busy && !st.pending;
  assign accept = o_slotb_ready && i_slotb.valid && o_slotb_run && slotb_avail
               && (nwords != 4'h0);

  always_comb begin
    cfg_word = 16'h0000;
    cfg_word[scc_pkg::SCC_BIT_RDOUT_FMT]   = st.cfg.rdout_fmt;
    cfg_word[scc_pkg::SCC_BIT_OVRN_POLICY] = st.cfg.ovrn_policy;
    cfg_word[scc_pkg::SCC_POS_SLOTB_FMT +: scc_pkg::SCC_FMT_W] = st.cfg.slotb_fmt;
    cfg_word[scc_pkg::SCC_BIT_SECOND_SLOT_ENABLE]    = st.cfg.second_slot_enable;
    cfg_word[scc_pkg::SCC_POS_SLOTA_FMT +: scc_pkg::SCC_FMT_W] = st.cfg.slota_fmt;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st     = st;
    next_st.ack = 1'b0;
    if (st.pending) begin
      // Write already acknowledged; now everything returns to defaults
      next_st = scc_reset_state();
    end else begin
      if (i_reg.wr || i_reg.rd) begin
        next_st.ack   = 1'b1;
        next_st.rdata = 16'h0000;
      end
      if (i_reg.rd) begin
        case (i_reg.addr)
          scc_pkg::SCC_OFS_MODE:      next_st.rdata = {14'h0000, st.mode};
          scc_pkg::SCC_OFS_FIFO_SLOT: next_st.rdata = cfg_word;
          default:                    next_st.rdata = 16'h0000;
        endcase
      end
      if (i_reg.wr) begin
        case (i_reg.addr)
          scc_pkg::SCC_OFS_SOFT_RESET: begin
            if (i_reg.wdata[scc_pkg::SCC_BIT_SOFT_RESET]) begin
              next_st.pending = 1'b1;
            end
          end
          scc_pkg::SCC_OFS_MODE: begin
            // Code 3 is unassigned, so such a write leaves the mode alone
            if (i_reg.wdata[1:0] != 2'h3) begin
              next_st.mode = scc_pkg::scc_mode_e'(i_reg.wdata[1:0]);
            end
          end
          scc_pkg::SCC_OFS_FIFO_SLOT: begin
            next_st.cfg.rdout_fmt   = i_reg.wdata[scc_pkg::SCC_BIT_RDOUT_FMT];
            next_st.cfg.ovrn_policy = i_reg.wdata[scc_pkg::SCC_BIT_OVRN_POLICY];
            next_st.cfg.slotb_fmt   = i_reg.wdata[scc_pkg::SCC_POS_SLOTB_FMT +: scc_pkg::SCC_FMT_W];
            next_st.cfg.second_slot_enable    = i_reg.wdata[scc_pkg::SCC_BIT_SECOND_SLOT_ENABLE];
            next_st.cfg.slota_fmt   = i_reg.wdata[scc_pkg::SCC_POS_SLOTA_FMT +: scc_pkg::SCC_FMT_W];
          end
          default: begin
          end
        endcase
      end
      // Serialiser: one 16-bit word per cycle, upper half of 32-bit values first
      if (st.busy) begin
        next_st.idx  = st.idx + 3'h1;
        next_st.left = st.left - 4'h1;
        if (st.left == 4'h1) begin
          next_st.busy = 1'b0;
        end
      end else if (accept) begin
        next_st.busy  = 1'b1;
        next_st.left  = nwords;
        next_st.idx   = 3'h0;
        next_st.words = '0;
        case (st.cfg.slotb_fmt)
          scc_pkg::SCC_FMT_SUM16: begin
            next_st.words[0] = sum16;
          end
          scc_pkg::SCC_FMT_SUM32: begin
            next_st.words[0] = sum32[31:16];
            next_st.words[1] = sum32[15:0];
          end
          scc_pkg::SCC_FMT_CH16: begin
            for (int k = 0; k < 4; k++) begin
              next_st.words[k] = i_slotb.ch16[k];
            end
          end
          default: begin
            for (int k = 0; k < 4; k++) begin
              next_st.words[2*k]   = i_slotb.ch32[k][31:16];
              next_st.words[2*k+1] = i_slotb.ch32[k][15:0];
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      st <= scc_reset_state();
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Sub-blocks
  // ----------------------------------------------------------------
  scc_fifo_gate u_gate (
    .i_clock        (i_clock),
    .i_sys_rst      (i_sys_rst),
    .i_clear        (st.pending),
    .i_word_valid   (st.busy),
    .i_policy       (st.cfg.ovrn_policy),
    .i_fifo_full    (i_fifo_full),
    .o_push         (o_fifo_push),
    .o_drop_oldest  (o_fifo_drop_oldest),
    .o_overrun_seen (o_overrun_seen)
  );

  scc_readback #(
    .SUM_W (SUM_W)
  ) u_readback (
    .i_clock     (i_clock),
    .i_sys_rst   (i_sys_rst),
    .i_block_sum (i_block_sum),
    .i_log2_n    (i_avg_factor_b),
    .i_avg_mode  (st.cfg.rdout_fmt),
    .o_value     (o_readback_value)
  );

  assign o_reg_ack    = st.ack;
  assign o_reg_rdata  = st.rdata;
  assign o_mode       = st.mode;
  assign o_cfg        = st.cfg;
  assign o_soft_reset = st.pending;
  assign o_fifo_word  = st.words[st.idx];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic reset_wr;
  logic accept_q;
  assign reset_wr = i_reg.wr && !st.pending && (i_reg.addr == scc_pkg::SCC_OFS_SOFT_RESET)
                 && i_reg.wdata[scc_pkg::SCC_BIT_SOFT_RESET];
  assign accept_q = accept;

  sequence s_restored;
    (o_mode == scc_pkg::SCC_MODE_STANDBY) && (o_cfg.ovrn_policy == scc_pkg::SCC_RST_OVRN_POLICY)
    && !o_cfg.second_slot_enable && (o_cfg.slotb_fmt == scc_pkg::SCC_FMT_NONE) && !st.busy;
  endsequence

  sequence s_words2;
    st.busy [*2] ##1 !st.busy;
  endsequence

  sequence s_words8;
    st.busy [*8] ##1 !st.busy;
  endsequence

  sequence s_words4;
    st.busy [*4] ##1 !st.busy;
  endsequence

  a_soft_reset_seq: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    reset_wr |=> (o_reg_ack && o_soft_reset) ##1 (s_restored and !o_reg_ack))
    else $error("soft reset did not ack then restore defaults");
  a_mode_normal: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (i_reg.wr && !st.pending && (i_reg.addr == scc_pkg::SCC_OFS_MODE) && (i_reg.wdata[1:0] == 2'h2))
    |=> (o_mode == scc_pkg::SCC_MODE_NORMAL) && o_reg_ack)
    else $error("mode write not applied");
  a_fmt_none_idle: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (o_slotb_ready && i_slotb.valid && (nwords == 4'h0)) |=> !st.busy [*2])
    else $error("format without data produced words");
  a_sum32_words: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (accept_q && (st.cfg.slotb_fmt == scc_pkg::SCC_FMT_SUM32)) |=> s_words2)
    else $error("32-bit sum not two words");
  a_ch32_words: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (accept_q && (st.cfg.slotb_fmt == scc_pkg::SCC_FMT_CH32)) |=> s_words8)
    else $error("extended channels not eight words");
  a_avail_block: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (o_slotb_ready && (i_avg_factor_a != i_avg_factor_b) && (st.cfg.slota_fmt != scc_pkg::SCC_FMT_NONE))
    |=> !st.busy)
    else $error("second slot stored despite averaging mismatch");
  a_slot_enable: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (st.busy && !$past(st.busy)) |-> $past(o_cfg.second_slot_enable && (o_mode == scc_pkg::SCC_MODE_NORMAL)))
    else $error("disabled second slot stored data");
  a_first_fmt: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (i_reg.wr && !st.pending && (i_reg.addr == scc_pkg::SCC_OFS_FIFO_SLOT))
    |=> (o_cfg.slota_fmt == $past(i_reg.wdata[4:2])))
    else $error("first slot format not at bits 4:2");
  a_sum16_word: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (accept_q && (st.cfg.slotb_fmt == scc_pkg::SCC_FMT_SUM16)) |=> (st.busy ##1 !st.busy))
    else $error("16-bit sum not one word");
  a_ch16_words: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (accept_q && (st.cfg.slotb_fmt == scc_pkg::SCC_FMT_CH16)) |=> s_words4)
    else $error("channel samples not four words");
  a_ch16_first: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (accept_q && (st.cfg.slotb_fmt == scc_pkg::SCC_FMT_CH16)) |=> (o_fifo_word == $past(i_slotb.ch16[0])))
    else $error("first channel word wrong");
  a_mode_hold: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (!(i_reg.wr && (i_reg.addr == scc_pkg::SCC_OFS_MODE)) && !st.pending)
    |=> $stable(o_mode))
    else $error("mode changed without a mode write");
  a_first_fmt_read: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (i_reg.rd && !st.pending && (i_reg.addr == scc_pkg::SCC_OFS_FIFO_SLOT))
    |=> (o_reg_rdata[4:2] == $past(o_cfg.slota_fmt)))
    else $error("first slot format not read at bits 4:2");
  a_overrun_clear: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    o_soft_reset |=> !o_overrun_seen)
    else $error("overrun flag survived soft reset");
  a_reset_policy: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    o_soft_reset
    |=> (o_cfg.ovrn_policy == scc_pkg::SCC_RST_OVRN_POLICY) && (o_cfg.rdout_fmt == scc_pkg::SCC_RST_RDOUT_FMT))
    else $error("soft reset left policy or readback format");

endmodule

// file: common/scc_pkg.sv
// Shared constants and carrier types for the sensor core control registers.
// Assumes one system clock; register accesses arrive already decoded from the
// serial port front end on that same clock.
//
// Overview of operation
// - Reset bit write acks, then defaults, standby
// - Mode field: 0 standby, 1 program, 2 normal
// - Readback format: 0 block sum, 1 average
// - Overrun policy 0: overwrite oldest when full
// - Overrun policy 1 (default): discard when full
// - Second slot format 0 stores nothing; reserved codes
// - Codes 1/2: four-channel sum, 16 or 32 bits
// - Codes 4/6: four channels, 16 or 32 bits
// - Second slot stored only if averaging matches or first slot format is 0
// - Second slot runs only when enabled
// - First slot format at bits 4:2, same coding
package scc_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] SCC_OFS_SOFT_RESET = 8'h0f;
  localparam logic [7:0] SCC_OFS_MODE       = 8'h10;
  localparam logic [7:0] SCC_OFS_FIFO_SLOT  = 8'h11;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SCC_BIT_SOFT_RESET   = 0;
  localparam int SCC_BIT_RDOUT_FMT    = 13;
  localparam int SCC_BIT_OVRN_POLICY  = 12;
  localparam int SCC_POS_SLOTB_FMT    = 6;
  localparam int SCC_BIT_SECOND_SLOT_ENABLE     = 5;
  localparam int SCC_POS_SLOTA_FMT    = 2;
  localparam int SCC_FMT_W            = 3;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic       SCC_RST_RDOUT_FMT   = 1'h0;
  localparam logic       SCC_RST_OVRN_POLICY = 1'h1;
  localparam logic [2:0] SCC_RST_FMT         = 3'h0;
  localparam logic       SCC_RST_SECOND_SLOT_ENABLE    = 1'h0;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SCC_MODE_STANDBY,
    SCC_MODE_PROGRAM,
    SCC_MODE_NORMAL
  } scc_mode_e;

  localparam logic [2:0] SCC_FMT_NONE  = 3'h0;
  localparam logic [2:0] SCC_FMT_SUM16 = 3'h1;
  localparam logic [2:0] SCC_FMT_SUM32 = 3'h2;
  localparam logic [2:0] SCC_FMT_CH16  = 3'h4;
  localparam logic [2:0] SCC_FMT_CH32  = 3'h6;

  // FIFO word counts per sample for each format
  localparam logic [3:0] SCC_WORDS_SUM16 = 4'h1;
  localparam logic [3:0] SCC_WORDS_SUM32 = 4'h2;
  localparam logic [3:0] SCC_WORDS_CH16  = 4'h4;
  localparam logic [3:0] SCC_WORDS_CH32  = 4'h8;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } scc_reg_req_s;

  typedef struct packed {
    logic             valid;
    logic [3:0][15:0] ch16;
    logic [3:0][31:0] ch32;
  } scc_sample_s;

  typedef struct packed {
    logic       rdout_fmt;
    logic       ovrn_policy;
    logic [2:0] slotb_fmt;
    logic       second_slot_enable;
    logic [2:0] slota_fmt;
  } scc_cfg_s;

  // Words pushed per sample; reserved codes push nothing
  function automatic logic [3:0] scc_words(input logic [2:0] fmt);
    case (fmt)
      SCC_FMT_SUM16: scc_words = SCC_WORDS_SUM16;
      SCC_FMT_SUM32: scc_words = SCC_WORDS_SUM32;
      SCC_FMT_CH16:  scc_words = SCC_WORDS_CH16;
      SCC_FMT_CH32:  scc_words = SCC_WORDS_CH32;
      default:       scc_words = 4'h0;
    endcase
  endfunction

endpackage

// file: core/scc_fifo_gate.sv
// FIFO write gate applying the overrun policy to each outgoing word.
// Assumes the FIFO full flag is on the same clock and valid in the push cycle.
`timescale 1ns/1ps
module scc_fifo_gate (
  // Clock and reset
  input  wire logic i_clock,
  input  wire logic i_sys_rst,
  input  wire logic i_clear,
  // Word source and policy
  input  wire logic i_word_valid,
  input  wire logic i_policy,
  // FIFO side
  input  wire logic i_fifo_full,
  output logic      o_push,
  output logic      o_drop_oldest,
  output logic      o_overrun_seen
);

  logic overrun;
  logic next_overrun;

  // Policy 0 overwrites the oldest entry; policy 1 drops the new word
  assign o_push        = i_word_valid && (!i_fifo_full || !i_policy);
  assign o_drop_oldest = i_word_valid && i_fifo_full && !i_policy;

  always_comb begin
    next_overrun = overrun || (i_word_valid && i_fifo_full);
    if (i_clear) begin
      next_overrun = 1'b0;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      overrun <= 1'b0;
    end else begin
      overrun <= next_overrun;
    end
  end

  assign o_overrun_seen = overrun;

  a_wrap_overwrite: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (i_word_valid && i_fifo_full && !i_policy) |-> (o_push && o_drop_oldest))
    else $error("wrap policy did not overwrite oldest");
  a_keep_discard: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (i_word_valid && i_fifo_full && i_policy) |-> (!o_push && !o_drop_oldest))
    else $error("keep policy pushed into full fifo");

endmodule

// file: core/scc_readback.sv
// Extended data readback: block sum or block average of N samples.
// Assumes N is two to the power of the averaging factor.
`timescale 1ns/1ps
module scc_readback #(
  parameter int SUM_W = 27
) (
  // Clock and reset
  input  wire logic             i_clock,
  input  wire logic             i_sys_rst,
  // Accumulated block and settings
  input  wire logic [SUM_W-1:0] i_block_sum,
  input  wire logic [2:0]       i_log2_n,
  input  wire logic             i_avg_mode,
  // Readback value
  output logic      [SUM_W-1:0] o_value
);

  logic [SUM_W-1:0] value;
  logic [SUM_W-1:0] next_value;

  // Truncating average; the shift keeps this free of a divider
  always_comb begin
    next_value = i_avg_mode ? (i_block_sum >> i_log2_n) : i_block_sum;
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      value <= '0;
    end else begin
      value <= next_value;
    end
  end

  assign o_value = value;

  a_readback_avg: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    i_avg_mode |=> (o_value == ($past(i_block_sum) >> $past(i_log2_n))))
    else $error("average readback mismatch");
  a_readback_sum: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    !i_avg_mode |=> (o_value == $past(i_block_sum)))
    else $error("sum readback mismatch");

endmodule

// file: bench/scc_host_model.sv
// Host model: issues single-cycle requests on the decoded register port.
// Assumes the bench checks read data; the host only paces requests.
`timescale 1ns/1ps
module scc_host_model (
  // Clock
  input  wire logic             i_clock,
  // Register port
  output scc_pkg::scc_reg_req_s o_reg,
  input  wire logic             i_reg_ack
);
  bit hung;

  initial o_reg = '0;

  // ----------------------------------------------------------------
  // One access: pulse the strobe, then wait a bounded time for the ack
  // ----------------------------------------------------------------
  task automatic access(input bit w, input logic [7:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge i_clock);
    o_reg <= '{wr: w, rd: !w, addr: a, wdata: w ? d : 16'h0};
    @(posedge i_clock);
    // Released lines show garbage so nothing leans on stale values
    o_reg <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    do begin
      @(posedge i_clock);
      n++;
    end while (i_reg_ack !== 1'b1 && n < 8);
    if (n == 8) hung = 1'b1;
  endtask
endmodule

// file: bench/testbench.sv
// Self-checking bench for the control register bank.
// Assumes scc_regs is the top; the host model drives its register port.
`timescale 1ns/1ps
module testbench;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic                  i_clock = 1'b0;
  logic                  i_sys_rst = 1'b1;
  wire scc_pkg::scc_reg_req_s i_reg;
  scc_pkg::scc_sample_s  i_slotb = '0;
  logic [2:0]            i_avg_factor_a = 3'h3;
  logic [2:0]            i_avg_factor_b = 3'h3;
  logic                  i_fifo_full = 1'b0;
  logic [26:0]           i_block_sum = 27'h0;
  logic                  o_reg_ack, o_soft_reset, o_slotb_run, o_slotb_ready;
  logic                  o_fifo_push, o_fifo_drop_oldest, o_overrun_seen;
  logic [15:0]           o_reg_rdata, o_fifo_word;
  scc_pkg::scc_mode_e    o_mode;
  scc_pkg::scc_cfg_s     o_cfg;
  logic [26:0]           o_readback_value;
  int                    fail_count = 0;
  int                    cmp_count = 0;
  bit                    exp_drop = 1'b0;
  logic [16:0]           reg_q[$];
  logic [16:0]           fifo_q[$];
  logic [2:0]            fmts[6] = '{3'h1, 3'h2, 3'h4, 3'h6, 3'h0, 3'h3};

  initial begin
    forever #2 i_clock = ~i_clock;
  end

  scc_host_model host (.i_clock(i_clock), .o_reg(i_reg), .i_reg_ack(o_reg_ack));

  scc_regs #(.SUM_W(27)) DUT (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_reg(i_reg), .o_reg_ack(o_reg_ack),
    .o_reg_rdata(o_reg_rdata), .o_mode(o_mode), .o_cfg(o_cfg), .o_soft_reset(o_soft_reset),
    .i_avg_factor_a(i_avg_factor_a), .i_avg_factor_b(i_avg_factor_b), .i_slotb(i_slotb),
    .o_slotb_run(o_slotb_run), .o_slotb_ready(o_slotb_ready), .i_fifo_full(i_fifo_full),
    .o_fifo_push(o_fifo_push), .o_fifo_drop_oldest(o_fifo_drop_oldest), .o_fifo_word(o_fifo_word),
    .o_overrun_seen(o_overrun_seen), .i_block_sum(i_block_sum), .o_readback_value(o_readback_value)
  );

  // ----------------------------------------------------------------
  // Compare, report, close
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic summarize();
    if (host.hung) fail_count++;
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    #200000;
    fail_count++;
    summarize();
  end

  // ----------------------------------------------------------------
  // Drivers that note what they expect
  // ----------------------------------------------------------------
  function automatic logic [15:0] cfg(bit rdo, bit pol, logic [2:0] fb, bit en, logic [2:0] fa);
    return {2'h0, rdo, pol, 3'h0, fb, en, fa, 2'h0};
  endfunction

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_q.push_back(17'h0);
    host.access(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    reg_q.push_back({1'b1, exp});
    host.access(1'b0, a, 16'h0);
  endtask

  function automatic void note(input logic [15:0] w);
    fifo_q.push_back({exp_drop, w});
  endfunction

  // Channel values kept small so both sum widths agree and none saturate
  task automatic sample(input logic [2:0] fmt, input bit go);
    scc_pkg::scc_sample_s s;
    logic [31:0] sum;
    s = '0;
    sum = 32'h0;
    s.valid = 1'b1;
    for (int i = 0; i < 4; i++) begin
      s.ch16[i] = 16'($urandom_range(16'h3fff));
      s.ch32[i] = {16'h0, s.ch16[i]};
      sum += s.ch16[i];
    end
    if (go && fmt == 3'h1) note(sum[15:0]);
    if (go && fmt == 3'h2) note(sum[31:16]);
    if (go && fmt == 3'h2) note(sum[15:0]);
    for (int i = 0; i < 4; i++) begin
      if (go && fmt == 3'h4) note(s.ch16[i]);
      if (go && fmt == 3'h6) note(s.ch32[i][31:16]);
      if (go && fmt == 3'h6) note(s.ch32[i][15:0]);
    end
    @(posedge i_clock);
    i_slotb <= s;
    @(posedge i_clock);
    i_slotb.valid <= 1'b0;
    repeat (12) @(posedge i_clock);
    check("words missing", 32'h0, 32'(fifo_q.size()));
  endtask

  // ----------------------------------------------------------------
  // Monitor: oldest note against each result that appears
  // ----------------------------------------------------------------
  always @(posedge i_clock) begin
    logic [16:0] n;
    if (o_reg_ack === 1'b1) begin
      n = (reg_q.size() != 0) ? reg_q.pop_front() : 17'h1dead;
      if (n[16]) check("rdata", {16'h0, n[15:0]}, {16'h0, o_reg_rdata});
    end
    if (o_fifo_push === 1'b1) begin
      n = (fifo_q.size() != 0) ? fifo_q.pop_front() : 17'h1dead;
      check("fifo word", {15'h0, n}, {15'h0, o_fifo_drop_oldest, o_fifo_word});
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(81));
    repeat (16) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    rd(8'h10, 16'h0000);
    rd(8'h11, 16'h1000);
    rd(8'h0f, 16'h0000);
    rd(8'h20, 16'h0000);
    for (int m = 0; m < 3; m++) begin
      wr(8'h10, 16'(m));
      rd(8'h10, 16'(m));
      check("mode", 32'(m), 32'(o_mode));
    end
    wr(8'h10, 16'h0003);
    rd(8'h10, 16'h0002);
    i_block_sum <= 27'($urandom);
    wr(8'h11, cfg(1'b1, 1'b1, 3'h0, 1'b0, 3'h0));
    rd(8'h11, 16'h3000);
    check("config", 32'h180, 32'(o_cfg));
    check("average", 32'(i_block_sum >> 3), 32'(o_readback_value));
    wr(8'h11, cfg(1'b0, 1'b1, 3'h0, 1'b0, 3'h0));
    // Readback is registered behind the format bit, so let one edge pass
    @(posedge i_clock);
    check("block sum", 32'(i_block_sum), 32'(o_readback_value));
    foreach (fmts[k]) begin
      wr(8'h11, cfg(1'b0, 1'b1, fmts[k], 1'b1, 3'h1));
      check("run", 32'h1, 32'(o_slotb_run));
      sample(fmts[k], fmts[k] inside {3'h1, 3'h2, 3'h4, 3'h6});
    end
    i_avg_factor_a <= 3'h1;
    wr(8'h11, cfg(1'b0, 1'b1, 3'h1, 1'b1, 3'h1));
    sample(3'h1, 1'b0);
    wr(8'h11, cfg(1'b0, 1'b1, 3'h4, 1'b1, 3'h0));
    sample(3'h4, 1'b1);
    wr(8'h11, cfg(1'b0, 1'b1, 3'h4, 1'b0, 3'h0));
    check("run", 32'h0, 32'(o_slotb_run));
    sample(3'h4, 1'b0);
    i_fifo_full <= 1'b1;
    exp_drop = 1'b1;
    wr(8'h11, cfg(1'b0, 1'b0, 3'h2, 1'b1, 3'h0));
    sample(3'h2, 1'b1);
    exp_drop = 1'b0;
    wr(8'h11, cfg(1'b0, 1'b1, 3'h2, 1'b1, 3'h0));
    sample(3'h2, 1'b0);
    check("overrun", 32'h1, 32'(o_overrun_seen));
    i_fifo_full <= 1'b0;
    wr(8'h0f, 16'h0001);
    check("soft reset", 32'h1, 32'(o_soft_reset));
    rd(8'h11, 16'h1000);
    rd(8'h10, 16'h0000);
    check("overrun", 32'h0, 32'(o_overrun_seen));
    check("mode", 32'h0, 32'(o_mode));
    check("ready", 32'h1, 32'(o_slotb_ready));
    repeat (4) @(posedge i_clock);
    check("acks left", 32'h0, 32'(reg_q.size()));
    summarize();
  end
endmodule
